// ---- src/mppc_top.v ----
// port pin controller top: apb registers, port instances, external and key interrupts
`default_nettype none
`include "mppc_regs.vh"
module mppc_top (
    input wire core_clk_i,                    // system clock, 25 MHz
    input wire reset_i,                       // synchronous reset, active high
    input wire psel_i,                        // apb select
    input wire penable_i,                     // apb enable
    input wire pwrite_i,                      // apb write
    input wire [`MPPC_AW-1:0] paddr_i,        // apb byte address
    input wire [`MPPC_DW-1:0] pwdata_i,       // apb write data
    output reg [`MPPC_DW-1:0] prdata_o,       // apb read data
    output reg pready_o,                      // apb ready
    output reg pslverr_o,                     // apb error, unmapped address
    input wire [`MPPC_NPIN-1:0] pin_in_i,     // pin levels
    input wire [`MPPC_NPIN-1:0] alt_out_i,    // peripheral output values
    input wire [`MPPC_NPIN-1:0] alt_oe_i,     // peripheral drive enables
    output wire [`MPPC_NPIN-1:0] pin_out_o,   // pin output values
    output wire [`MPPC_NPIN-1:0] pin_oe_o,    // pin output enables
    output wire [`MPPC_NPIN-1:0] pull_en_o,   // pull-up enables
    output wire [`MPPC_NPIN-1:0] ctrl_mode_o, // control mode per pin
    output wire [`MPPC_NPIN-1:0] pin_sync_o,  // synchronised levels to peripherals
    output reg irq_o                          // level interrupt
);
    // pins per port number, zero where no port exists
    function integer pw;
        input integer g;
        begin
            case (g)
                0: pw = `MPPC_P0_W;
                1, 2, 7: pw = `MPPC_P8_W;
                3, 4, 5, 6: pw = `MPPC_P4_W;
                12: pw = `MPPC_P12_W;
                13: pw = `MPPC_P13_W;
                14: pw = `MPPC_P14_W;
                default: pw = 0;
            endcase
        end
    endfunction

    // first pin of each port in the flat pin vectors
    function integer pb;
        input integer g;
        begin
            case (g)
                1: pb = `MPPC_P1_BASE;
                2: pb = `MPPC_P2_BASE;
                3: pb = `MPPC_P3_BASE;
                4: pb = `MPPC_P4_BASE;
                5: pb = `MPPC_P5_BASE;
                6: pb = `MPPC_P6_BASE;
                7: pb = `MPPC_P7_BASE;
                12: pb = `MPPC_P12_BASE;
                13: pb = `MPPC_P13_BASE;
                14: pb = `MPPC_P14_BASE;
                default: pb = `MPPC_P0_BASE;
            endcase
        end
    endfunction

    // which pins carry a pull-up option
    function [7:0] pum;
        input integer g;
        begin
            case (g)
                2, 6, 13: pum = `MPPC_MASK_NONE;
                12: pum = `MPPC_MASK_BIT0;
                default: pum = `MPPC_MASK_ALL;
            endcase
        end
    endfunction

    // pin of each external interrupt input
    function integer ipin;
        input integer k;
        begin
            case (k)
                0: ipin = `MPPC_P12_BASE;
                5: ipin = `MPPC_P1_BASE + `MPPC_INTP5_BIT;
                6: ipin = `MPPC_P14_BASE;
                7: ipin = `MPPC_P14_BASE + 1;
                default: ipin = `MPPC_P3_BASE + k - 1;
            endcase
        end
    endfunction

    wire [3:0] reg_sel = paddr_i[`MPPC_AW-1:8];
    wire [3:0] blk_sel = paddr_i[7:4];
    wire [1:0] word_sel = paddr_i[3:2];
    wire setup = psel_i & ~penable_i;
    wire access = psel_i & penable_i & pready_o;
    wire port_hit = (reg_sel == `MPPC_REGION_PORT) && (pw(blk_sel) != 0);
    wire irq_hit = (reg_sel == `MPPC_REGION_IRQ) && (blk_sel == `MPPC_IRQ_BLOCK);
    wire wr = access & pwrite_i & (port_hit | irq_hit);

    wire [7:0] rd_w [0:`MPPC_NPORT-1];
    wire [`MPPC_NEXT-1:0] ext_evt;
    wire [7:0] key_evt;

    reg [15:0] edge_q;
    reg [`MPPC_NSTAT-1:0] sts_q, en_q;
    reg [`MPPC_NSTAT-1:0] sts_d, clr_w, evt;
    reg [`MPPC_DW-1:0] rd_d;

    genvar g;
    generate
        for (g = 0; g < `MPPC_NPORT; g = g + 1) begin : gp
            if (pw(g) != 0) begin : gi
                wire [3:0] we = (wr && port_hit && blk_sel == g) ? (4'h1 << word_sel) : 4'h0;
                mppc_port #(
                    .W(pw(g)),
                    .PU_MASK(pum(g)),
                    .MODE_RST(g == 2 ? `MPPC_MODE_ANALOG_RST : `MPPC_MODE_RST),
                    .OD(g == 6 ? 1 : 0),
                    .OONLY(g == 13 ? 1 : 0)
                ) u_port (
                    .core_clk_i(core_clk_i),
                    .reset_i(reset_i),
                    .we_i(we),
                    .wdata_i(pwdata_i[7:0]),
                    .rsel_i(word_sel),
                    .rd_o(rd_w[g]),
                    .pin_i(pin_in_i[pb(g) +: pw(g)]),
                    .alt_out_i(alt_out_i[pb(g) +: pw(g)]),
                    .alt_oe_i(alt_oe_i[pb(g) +: pw(g)]),
                    .pin_out_o(pin_out_o[pb(g) +: pw(g)]),
                    .pin_oe_o(pin_oe_o[pb(g) +: pw(g)]),
                    .pull_en_o(pull_en_o[pb(g) +: pw(g)]),
                    .mode_o(ctrl_mode_o[pb(g) +: pw(g)]),
                    .sync_o(pin_sync_o[pb(g) +: pw(g)])
                );
            end else begin : gn
                assign rd_w[g] = `MPPC_ZERO8;
            end
        end

        for (g = 0; g < `MPPC_NEXT; g = g + 1) begin : ge
            mppc_edge u_ext (
                .core_clk_i(core_clk_i),
                .reset_i(reset_i),
                .lvl_i(pin_sync_o[ipin(g)]),
                .sel_i(edge_q[2*g +: 2]),
                .evt_o(ext_evt[g])
            );
        end

        for (g = 0; g < 8; g = g + 1) begin : gk
            mppc_edge u_key (
                .core_clk_i(core_clk_i),
                .reset_i(reset_i),
                .lvl_i(pin_sync_o[`MPPC_P7_BASE + g]),
                .sel_i(`MPPC_EDGE_FALL),
                .evt_o(key_evt[g])
            );
        end
    endgenerate

    // status and read mux
    always @* begin
        evt = {`MPPC_NSTAT{1'b0}};
        evt[`MPPC_NEXT-1:0] = ext_evt;
        evt[`MPPC_KEY_BIT] = |(key_evt & ctrl_mode_o[`MPPC_P7_BASE +: 8]);
        clr_w = {`MPPC_NSTAT{1'b0}};
        if (wr && irq_hit && word_sel == `MPPC_REG_CLR)
            clr_w = pwdata_i[`MPPC_NSTAT-1:0];
        sts_d = (sts_q & ~clr_w) | evt;
        rd_d = {`MPPC_DW{1'b0}};
        if (port_hit) begin
            rd_d[7:0] = rd_w[blk_sel];
        end else if (irq_hit) begin
            case (word_sel)
                `MPPC_REG_EDGE: rd_d[15:0] = edge_q;
                `MPPC_REG_STAT: rd_d[`MPPC_NSTAT-1:0] = sts_q;
                `MPPC_REG_EN: rd_d[`MPPC_NSTAT-1:0] = en_q;
                default: rd_d = {`MPPC_DW{1'b0}};
            endcase
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= {`MPPC_DW{1'b0}};
            edge_q <= `MPPC_EDGE_RST;
            en_q <= `MPPC_STAT_RST;
            sts_q <= `MPPC_STAT_RST;
            irq_o <= 1'b0;
        end else begin
            pready_o <= setup;
            if (setup) begin
                prdata_o <= rd_d;
                pslverr_o <= ~(port_hit | irq_hit);
            end
            if (wr && irq_hit && word_sel == `MPPC_REG_EDGE)
                edge_q <= pwdata_i[15:0];
            if (wr && irq_hit && word_sel == `MPPC_REG_EN)
                en_q <= pwdata_i[`MPPC_NSTAT-1:0];
            sts_q <= sts_d;
            irq_o <= |(sts_d & en_q);
        end
    end
endmodule
`default_nettype wire

// ---- src/mppc_regs.vh ----
// register map, pin layout and reset values of the port pin controller
`ifndef MPPC_REGS_VH
`define MPPC_REGS_VH
// apb
`define MPPC_AW 12
`define MPPC_DW 32
`define MPPC_REGION_PORT 4'h0
`define MPPC_REGION_IRQ 4'h1
// per-port word index in paddr[3:2], port number in paddr[7:4]
`define MPPC_REG_DATA 2'h0
`define MPPC_REG_DIR 2'h1
`define MPPC_REG_PULL 2'h2
`define MPPC_REG_MODE 2'h3
// interrupt words in region 1, block 0
`define MPPC_IRQ_BLOCK 4'h0
`define MPPC_REG_EDGE 2'h0
`define MPPC_REG_STAT 2'h1
`define MPPC_REG_EN 2'h2
`define MPPC_REG_CLR 2'h3
// pins
`define MPPC_NPIN 55
`define MPPC_NPORT 15
`define MPPC_P0_BASE 0
`define MPPC_P1_BASE 7
`define MPPC_P2_BASE 15
`define MPPC_P3_BASE 23
`define MPPC_P4_BASE 27
`define MPPC_P5_BASE 31
`define MPPC_P6_BASE 35
`define MPPC_P7_BASE 39
`define MPPC_P12_BASE 47
`define MPPC_P13_BASE 52
`define MPPC_P14_BASE 53
`define MPPC_P0_W 7
`define MPPC_P8_W 8
`define MPPC_P4_W 4
`define MPPC_P12_W 5
`define MPPC_P13_W 1
`define MPPC_P14_W 2
`define MPPC_INTP5_BIT 6
// masks and reset values
`define MPPC_MASK_ALL 8'hFF
`define MPPC_MASK_NONE 8'h00
`define MPPC_MASK_BIT0 8'h01
`define MPPC_DIR_RST 8'hFF
`define MPPC_MODE_RST 8'h00
`define MPPC_MODE_ANALOG_RST 8'hFF
`define MPPC_ZERO8 8'h00
// edge select codes, two bits per external interrupt input
`define MPPC_EDGE_NONE 2'h0
`define MPPC_EDGE_RISE 2'h1
`define MPPC_EDGE_FALL 2'h2
`define MPPC_EDGE_BOTH 2'h3
`define MPPC_NEXT 8
`define MPPC_NSTAT 9
`define MPPC_KEY_BIT 8
`define MPPC_EDGE_RST 16'h0000
`define MPPC_STAT_RST 9'h000
`endif

// ---- src/mppc_edge.v ----
// valid-edge detector for one already synchronised interrupt level
`default_nettype none
`include "mppc_regs.vh"
module mppc_edge (
    input wire core_clk_i, // system clock
    input wire reset_i,    // synchronous reset, active high
    input wire lvl_i,      // synchronised pin level
    input wire [1:0] sel_i, // valid edge select
    output reg evt_o       // one-cycle event pulse
);
    reg prev_q;

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            // track the level in reset so an idle-high pin gives no false edge
            prev_q <= lvl_i;
            evt_o <= 1'b0;
        end else begin
            prev_q <= lvl_i;
            evt_o <= (sel_i[0] & lvl_i & ~prev_q) | (sel_i[1] & ~lvl_i & prev_q);
        end
    end
endmodule
`default_nettype wire

// ---- src/mppc_port.v ----
// one general-purpose port: latch, direction, pull-up, mode, pin sync and drive
`default_nettype none
`include "mppc_regs.vh"
module mppc_port #(
    parameter W = 8,
    parameter [7:0] PU_MASK = `MPPC_MASK_ALL,
    parameter [7:0] MODE_RST = `MPPC_MODE_RST,
    parameter OD = 0,
    parameter OONLY = 0
) (
    input wire core_clk_i,          // system clock
    input wire reset_i,             // synchronous reset, active high
    input wire [3:0] we_i,          // one-hot write strobe per register word
    input wire [7:0] wdata_i,       // write data
    input wire [1:0] rsel_i,        // register word selected for read
    output reg [7:0] rd_o,          // read data, zero above W
    input wire [W-1:0] pin_i,       // pin levels
    input wire [W-1:0] alt_out_i,   // alternate function output value
    input wire [W-1:0] alt_oe_i,    // alternate function drive enable
    output reg [W-1:0] pin_out_o,   // pin output value
    output reg [W-1:0] pin_oe_o,    // pin output enable
    output reg [W-1:0] pull_en_o,   // pull-up enable
    output wire [W-1:0] mode_o,     // 1 = alternate control function
    output wire [W-1:0] sync_o      // synchronised pin level
);
    localparam [7:0] DRST8 = `MPPC_DIR_RST;
    localparam [W-1:0] ONES = {W{1'b1}};
    localparam [W-1:0] ZERO = {W{1'b0}};
    localparam [W-1:0] PUM = PU_MASK[W-1:0];
    localparam [W-1:0] MRST = MODE_RST[W-1:0];
    localparam [W-1:0] DRST = DRST8[W-1:0];
    localparam [W-1:0] CFGM = OONLY ? ZERO : ONES;

    reg [W-1:0] lat_q, dir_q, pul_q, mod_q;
    reg [W-1:0] s1_q, s2_q, s3_q, sync_q;
    reg [W-1:0] drv, val, agree, oe_d, out_d;

    assign mode_o = mod_q;
    assign sync_o = sync_q;

    always @* begin
        drv = (mod_q & alt_oe_i) | (~mod_q & ~dir_q);
        val = (mod_q & alt_out_i) | (~mod_q & lat_q);
        agree = ~(s2_q ^ s3_q);
        if (OONLY != 0) begin
            oe_d = ONES;
            out_d = lat_q;
        end else if (OD != 0) begin
            oe_d = drv & ~val;
            out_d = ZERO;
        end else begin
            oe_d = drv;
            out_d = val;
        end
        rd_o = `MPPC_ZERO8;
        case (rsel_i)
            `MPPC_REG_DATA: rd_o[W-1:0] = (dir_q & sync_q) | (~dir_q & lat_q);
            `MPPC_REG_DIR: rd_o[W-1:0] = dir_q;
            `MPPC_REG_PULL: rd_o[W-1:0] = pul_q;
            `MPPC_REG_MODE: rd_o[W-1:0] = mod_q;
            default: rd_o = `MPPC_ZERO8;
        endcase
    end

    // synchroniser runs through reset, so the level has settled at release
    always @(posedge core_clk_i) begin
        s1_q <= OONLY ? ZERO : pin_i;
        s2_q <= s1_q;
        s3_q <= s2_q;
        sync_q <= (agree & s2_q) | (~agree & sync_q);
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            lat_q <= ZERO;
            dir_q <= DRST & CFGM;
            pul_q <= ZERO;
            mod_q <= MRST & CFGM;
            pin_out_o <= ZERO;
            pin_oe_o <= OONLY ? ONES : ZERO;
            pull_en_o <= ZERO;
        end else begin
            if (we_i[`MPPC_REG_DATA]) lat_q <= wdata_i[W-1:0];
            if (we_i[`MPPC_REG_DIR]) dir_q <= wdata_i[W-1:0] & CFGM;
            if (we_i[`MPPC_REG_PULL]) pul_q <= wdata_i[W-1:0] & PUM;
            if (we_i[`MPPC_REG_MODE]) mod_q <= wdata_i[W-1:0] & CFGM;
            pin_out_o <= out_d;
            pin_oe_o <= oe_d;
            pull_en_o <= pul_q & dir_q & ~mod_q;
        end
    end
endmodule
`default_nettype wire

// ---- bench/mppc_board.sv ----
// board model: resolves each pin from device drive, board drive and pull-up
`default_nettype none
module mppc_board (
    input wire logic clk_i, // clock
    input wire logic [54:0] out_i, // device value
    input wire logic [54:0] oe_i, // device drive
    input wire logic [54:0] pull_i, // pull-up on
    input wire logic [54:0] drv_i, // board drive
    input wire logic [54:0] val_i, // board value
    output logic [54:0] lvl_o // pin level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [54:0] flt_q = '0;
    // lines nobody holds change every cycle
    always @(posedge clk_i) flt_q <= ~flt_q;
    always_comb begin
        for (int i = 0; i < 55; i++) begin
            if (oe_i[i])
                lvl_o[i] = out_i[i];
            else if (drv_i[i])
                lvl_o[i] = val_i[i];
            else if (pull_i[i])
                lvl_o[i] = 1'b1;
            else
                lvl_o[i] = flt_q[i];
        end
    end
endmodule
`default_nettype wire

// ---- bench/mppc_top_asserts.sv ----
// assertions on the port pin controller top ports
`default_nettype none
module mppc_top_asserts (
    input wire logic core_clk_i, // clock
    input wire logic reset_i, // reset
    input wire logic psel_i, // select
    input wire logic penable_i, // enable
    input wire logic [11:0] paddr_i, // address
    input wire logic pready_o, // ready
    input wire logic pslverr_o, // error
    input wire logic [54:0] pin_in_i, // levels
    input wire logic [54:0] pin_out_o, // values
    input wire logic [54:0] pin_oe_o, // drives
    input wire logic [54:0] pull_en_o, // pull-ups
    input wire logic [54:0] ctrl_mode_o, // modes
    input wire logic [54:0] pin_sync_o, // synced
    input wire logic irq_o // interrupt
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    wire setup = psel_i & ~penable_i;
    wire hi = paddr_i[7:4] > 4'hB && paddr_i[7:4] < 4'hF;
    wire unmap = paddr_i[11:7] == 5'h01 && !hi;
    chk_unmap_err: assert property (setup && unmap |=> pready_o && pslverr_o)
        else $error("unmapped port accepted");
    chk_map_ok: assert property (setup && paddr_i[11:7] == 5'h00 |=>
        pready_o && !pslverr_o) else $error("mapped port refused");
    chk_oonly_drive: assert property (pin_oe_o[52])
        else $error("output-only pin released");
    chk_rst_low: assert property (disable iff (1'b0)
        reset_i |=> pin_oe_o[52] && !pin_out_o[52]) else $error("pin 52 not low");
    chk_rst_quiet: assert property (disable iff (1'b0)
        reset_i |=> !irq_o && pin_oe_o == 55'h10000000000000) else $error("reset state");
    chk_od_low: assert property (pin_out_o[38:35] == 4'h0)
        else $error("open drain drives high");
    chk_pull_mask: assert property (pull_en_o[22:15] == 8'h00 &&
        pull_en_o[38:35] == 4'h0 && pull_en_o[52:48] == 5'h00) else $error("pull mask");
    chk_analog_rst: assert property (disable iff (1'b0)
        $fell(reset_i) |-> ctrl_mode_o[22:15] == 8'hFF) else $error("port two mode");
    chk_sync_lat: assert property ((pin_in_i == $past(pin_in_i)) [*6] |->
        {pin_sync_o[54:53], pin_sync_o[51:0]} == {pin_in_i[54:53], pin_in_i[51:0]})
        else $error("sync level");
    cov_irq: cover property (!irq_o ##1 irq_o);
    cov_err: cover property (pready_o && pslverr_o);
    cov_od: cover property (pin_oe_o[35]);
endmodule
`default_nettype wire

// ---- bench/multi_port_pin_control_tb.sv ----
// self-checking bench for the port pin controller
`default_nettype none
`include "mppc_regs.vh"
module multi_port_pin_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DA = `MPPC_REG_DATA;
    localparam int DI = `MPPC_REG_DIR;
    localparam int PU = `MPPC_REG_PULL;
    localparam int MO = `MPPC_REG_MODE;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [54:0] alt_out_i = '0;
    logic [54:0] alt_oe_i = '0;
    logic [54:0] drv = '1;
    logic [54:0] val = '1;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, irq_o;
    wire [54:0] pin_in_i, pin_out_o, pin_oe_o, pull_en_o, ctrl_mode_o, pin_sync_o;
    integer errors = 0;
    integer checked = 0;
    integer cyc = 0;
    logic [31:0] rd;
    logic er;
    mppc_top u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_in_i(pin_in_i),
        .alt_out_i(alt_out_i), .alt_oe_i(alt_oe_i), .pin_out_o(pin_out_o),
        .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o), .ctrl_mode_o(ctrl_mode_o),
        .pin_sync_o(pin_sync_o), .irq_o(irq_o));
    mppc_board u_board (.clk_i(core_clk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
        .pull_i(pull_en_o), .drv_i(drv), .val_i(val), .lvl_o(pin_in_i));
    initial forever #20 core_clk_i = ~core_clk_i;
    task automatic test_done();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked = checked + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [11:0] pa(input int g, input int p, input int r);
        return 12'(g * 256 + p * 16 + r * 4);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1)
            @(posedge core_clk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic t_reset();
        chk("mode2", 8'hFF, ctrl_mode_o[22:15]);
        chk("oe", 55'h10000000000000, pin_oe_o);
        chk("out52", 1'b0, pin_out_o[52]);
        apb(1'b0, pa(0, 2, MO), 32'h0);
        chk("mode2reg", 32'hFF, rd);
    endtask
    task automatic t_width();
        int pn[8] = '{0, 1, 3, 4, 5, 7, 12, 14};
        int pw[8] = '{7, 8, 4, 4, 4, 8, 5, 2};
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, pa(0, pn[i], DA), 32'hFF);
            apb(1'b1, pa(0, pn[i], DI), 32'h0);
            apb(1'b0, pa(0, pn[i], DA), 32'h0);
            chk("width", (64'h1 << pw[i]) - 1, rd);
            apb(1'b1, pa(0, pn[i], DI), 32'hFF);
        end
        apb(1'b1, pa(0, 13, DA), 32'h1);
        tick(2);
        chk("oonly", 1'b1, pin_out_o[52]);
        apb(1'b0, pa(0, 13, DI), 32'h0);
        chk("dir13", 32'h0, rd);
    endtask
    task automatic t_dir_pull();
        val[10:7] <= 4'h2;
        apb(1'b1, pa(0, 1, DA), 32'hA5);
        apb(1'b1, pa(0, 1, DI), 32'h0F);
        tick(6);
        chk("oe1", 8'hF0, pin_oe_o[14:7]);
        chk("out1", 4'hA, pin_out_o[14:11]);
        apb(1'b0, pa(0, 1, DA), 32'h0);
        chk("rd1", 32'hA2, rd);
        drv[7] <= 1'b0;
        apb(1'b1, pa(0, 1, PU), 32'hFF);
        apb(1'b1, pa(0, 12, PU), 32'h1F);
        tick(6);
        chk("pull1", 8'h0F, pull_en_o[14:7]);
        chk("pull12", 5'h01, pull_en_o[51:47]);
        apb(1'b0, pa(0, 1, DA), 32'h0);
        chk("pullrd", 32'hA3, rd);
    endtask
    task automatic t_od_mode();
        apb(1'b1, pa(0, 6, DA), 32'h5);
        apb(1'b1, pa(0, 6, DI), 32'h0);
        tick(2);
        chk("oe6", 4'hA, pin_oe_o[38:35]);
        alt_out_i[7] <= 1'b1;
        alt_oe_i[7] <= 1'b1;
        apb(1'b1, pa(0, 1, DA), 32'h0);
        apb(1'b1, pa(0, 1, DI), 32'h0);
        apb(1'b1, pa(0, 1, MO), 32'h1);
        tick(2);
        chk("mode1", 8'h01, ctrl_mode_o[14:7]);
        chk("alt7", 2'b11, {pin_oe_o[7], pin_out_o[7]});
        chk("port8", 2'b10, {pin_oe_o[8], pin_out_o[8]});
        // board clocks the released serial clock pin, one level per two cycles
        for (int i = 0; i < 8; i++) begin
            val[37] <= i[0];
            tick(2);
            if (i > 1)
                chk("sclk", i[0], pin_sync_o[37]);
        end
    endtask
    task automatic t_edge();
        logic [1:0] c;
        val[23] <= 1'b0;
        apb(1'b1, pa(1, 0, 2), 32'h2);
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            apb(1'b1, pa(1, 0, 0), {28'h0, c, 2'b00});
            apb(1'b1, pa(1, 0, 3), 32'h1FF);
            val[23] <= 1'b1;
            tick(8);
            apb(1'b0, pa(1, 0, 1), 32'h0);
            chk("rise", c[0], rd[1]);
            chk("irq", c[0], irq_o);
            apb(1'b1, pa(1, 0, 3), 32'h1FF);
            val[23] <= 1'b0;
            tick(8);
            apb(1'b0, pa(1, 0, 1), 32'h0);
            chk("fall", c[1], rd[1]);
        end
        apb(1'b1, pa(1, 0, 2), 32'h0);
        apb(1'b1, pa(1, 0, 3), 32'h1FF);
        val[23] <= 1'b1;
        tick(8);
        chk("masked", 1'b0, irq_o);
        apb(1'b1, pa(1, 0, 2), 32'h2);
        tick(2);
        chk("unmask", 1'b1, irq_o);
        apb(1'b1, pa(1, 0, 3), 32'h2);
        tick(2);
        chk("clr", 1'b0, irq_o);
    endtask
    task automatic t_key_err();
        apb(1'b1, pa(1, 0, 2), 32'h100);
        val[40] <= 1'b0;
        tick(8);
        chk("keyport", 1'b0, irq_o);
        val[40] <= 1'b1;
        apb(1'b1, pa(0, 7, MO), 32'hFF);
        val[40] <= 1'b0;
        tick(8);
        apb(1'b0, pa(1, 0, 1), 32'h0);
        chk("keyctl", 2'b11, {rd[8], irq_o});
        apb(1'b1, pa(0, 9, DA), 32'hFF);
        chk("err", 1'b1, er);
        apb(1'b0, pa(0, 9, DA), 32'h0);
        chk("rd9", 33'h100000000, {er, rd});
        reset_i <= 1'b1;
        tick(2);
        chk("rst", 2'b10, {pin_oe_o[52], pin_out_o[52] | irq_o});
        reset_i <= 1'b0;
        tick(1);
        chk("mode2b", 8'hFF, ctrl_mode_o[22:15]);
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        t_reset();
        t_width();
        t_dir_pull();
        t_od_mode();
        t_edge();
        t_key_err();
        test_done();
    end
endmodule
bind mppc_top mppc_top_asserts u_chk (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pull_en_o(pull_en_o), .ctrl_mode_o(ctrl_mode_o), .pin_sync_o(pin_sync_o), .irq_o(irq_o));
`default_nettype wire
